/* omvc_pkg.sv */
/*
  Package for the operating mode and vector control block: stop and source
  encodings, vector addresses, pin-state carrier and reset values.
  Assumes a single bus clock domain at 20 MHz and a synchronous reset.
*/
package omvc_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PIN_W = 8;
  localparam int ADDR_W = 16;

  // ************************************************************
  // Vector map (even address holds the high byte)
  // ************************************************************
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SWI = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ = 16'hFFFA;
  localparam logic [15:0] VEC_LVD = 16'hFFF8;
  localparam logic [15:0] VEC_TPMCH0 = 16'hFFF4;
  localparam logic [15:0] VEC_TPMCH1 = 16'hFFF2;
  localparam logic [15:0] VEC_TPMOVF = 16'hFFF0;
  localparam logic [15:0] VEC_MTIM = 16'hFFE6;
  localparam logic [15:0] VEC_SPI = 16'hFFE4;
  localparam logic [15:0] VEC_SCIERR = 16'hFFE2;
  localparam logic [15:0] VEC_SCIRX = 16'hFFE0;
  localparam logic [15:0] VEC_SCITX = 16'hFFDE;
  localparam logic [15:0] VEC_IIC = 16'hFFDC;
  localparam logic [15:0] VEC_KBI = 16'hFFDA;
  localparam logic [15:0] VEC_ADC = 16'hFFD8;
  localparam logic [15:0] VEC_ACMP = 16'hFFD6;
  localparam logic [15:0] VEC_RTI = 16'hFFD0;
  localparam logic [15:0] USER_LO = 16'hFFC0;
  localparam logic [15:0] USER_HI = 16'hFFCF;
  localparam logic [15:0] ADDR_HI_OFS = 16'h0001;

  // ************************************************************
  // Pin reset value and NUM_SRC constant
  // ************************************************************
  localparam logic [7:0] PIN_RST_VAL = 8'h00;
  localparam logic [3:0] NUM_SRC = 4'hF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {STOP_NONE, STOP_1, STOP_2, STOP_3} omvc_stop_t;

  // Interrupt source index, priority low index first
  typedef enum logic [3:0] {
    SRC_SWI, SRC_IRQ, SRC_LVD, SRC_TPMCH0, SRC_TPMCH1, SRC_TPMOVF, SRC_MTIM,
    SRC_SPI, SRC_SCIERR, SRC_SCIRX, SRC_SCITX, SRC_IIC, SRC_KBI, SRC_ADC,
    SRC_ACMP, SRC_RTI
  } omvc_src_t;

  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] oe;
    logic [7:0] pue;
  } omvc_pins_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } omvc_fetch_t;

endpackage

/* omvc_vecmap.sv */
/*
  Vector address lookup for interrupt sources.
  Assumes the caller only presents sources that are mapped.
*/
`timescale 1ns/1ps
module omvc_vecmap (
  input  wire omvc_pkg::omvc_src_t i_src,
  output logic [15:0]              o_addr
);
  import omvc_pkg::*;

  always_comb begin
    case (i_src)
      SRC_SWI:    o_addr = VEC_SWI;
      SRC_IRQ:    o_addr = VEC_IRQ;
      SRC_LVD:    o_addr = VEC_LVD;
      SRC_TPMCH0: o_addr = VEC_TPMCH0;
      SRC_TPMCH1: o_addr = VEC_TPMCH1;
      SRC_TPMOVF: o_addr = VEC_TPMOVF;
      SRC_MTIM:   o_addr = VEC_MTIM;
      SRC_SPI:    o_addr = VEC_SPI;
      SRC_SCIERR: o_addr = VEC_SCIERR;
      SRC_SCIRX:  o_addr = VEC_SCIRX;
      SRC_SCITX:  o_addr = VEC_SCITX;
      SRC_IIC:    o_addr = VEC_IIC;
      SRC_KBI:    o_addr = VEC_KBI;
      SRC_ADC:    o_addr = VEC_ADC;
      SRC_ACMP:   o_addr = VEC_ACMP;
      SRC_RTI:    o_addr = VEC_RTI;
      default:    o_addr = VEC_SWI;
    endcase
  end

endmodule

/* omvc_top.sv */
/*
  Operating mode and vector control: run/background selection at reset,
  background entry, wait and stop modes, pin hold for stop2, vector fetch.
  Assumes the core presents events as one-cycle pulses on i_clock and that
  stop wake-up is signalled while the block clock is running again.
*/
`timescale 1ns/1ps

// Operation
// - Reset ends with pin high and no force reset: run mode
// - Run start fetches reset vector pair
// - Pin low at POR or force reset: background
// - Host halt command enters background
// - Background instruction enters background
// - Controller or trace breakpoint enters background
// - Wait halts CPU, clocks and regulator on
// - Stop modes gate CPU and bus clocks
// - Stop1 powers off registers, pins default
// - Stop2 latches pins, keeps RAM
// - Ack write releases pin hold latches
// - Stop3 keeps power, registers, pins
// - Fixed vectors for SWI, IRQ, LVD
// - Unused vector range left for user
module omvc_top (
  input  wire logic                 i_clock,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_clk_en,
  input  wire logic                 i_mode_select_pin,
  input  wire logic                 i_force_reset,
  input  wire logic                 i_halt_cmd,
  input  wire logic                 i_bg_instr,
  input  wire logic                 i_ctrl_break,
  input  wire logic                 i_trace_break,
  input  wire logic                 i_go_cmd,
  input  wire logic                 i_wait_instr,
  input  wire logic                 i_stop_instr,
  input  wire omvc_pkg::omvc_stop_t i_stop_sel,
  input  wire logic                 i_wake,
  input  wire logic                 i_ack_write,
  input  wire logic                 i_irq_req,
  input  wire omvc_pkg::omvc_src_t  i_irq_src,
  input  wire logic                 i_byte_valid,
  input  wire logic [7:0]           i_byte,
  input  wire omvc_pkg::omvc_pins_t i_port_regs,
  output omvc_pkg::omvc_pins_t      o_pins,
  output logic                      o_background,
  output logic                      o_run,
  output logic                      o_cpu_clk_en,
  output logic                      o_bus_clk_en,
  output logic                      o_regulator_full,
  output logic                      o_regs_powered,
  output logic                      o_ram_retain,
  output logic                      o_pin_hold,
  output logic                      o_ppd_flag,
  output omvc_pkg::omvc_fetch_t     o_fetch,
  output logic [15:0]               o_pc,
  output logic                      o_pc_valid
);
  import omvc_pkg::*;

  // ************************************************************
  // Input synchroniser for the mode select pin
  // ************************************************************
  logic ms_s1_q, ms_s2_q;
  // Sampled through reset, so a pin held low in reset is seen at release
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_clk_en) begin
      ms_s1_q <= i_mode_select_pin;
      ms_s2_q <= ms_s1_q;
    end
  end

  // ************************************************************
  // Mode state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_RESET, ST_VEC_HI, ST_VEC_LO, ST_RUN, ST_DEBUG, ST_WAIT, ST_STOP
  } omvc_state_t;

  omvc_state_t state_q;
  omvc_stop_t  stop_q;
  logic        rst_seen_q;
  logic        to_enter_background_instruction_q;
  logic [15:0] vec_q;
  logic [15:0] pc_q;
  logic        pc_valid_q;
  logic [15:0] vec_addr;
  logic        bg_event;

  omvc_vecmap u_vecmap (
    .i_src  (i_irq_src),
    .o_addr (vec_addr)
  );

  assign bg_event = i_halt_cmd | i_bg_instr | i_ctrl_break | i_trace_break;

  // Sample mode pin one cycle after reset release
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rst_seen_q <= 1'b0;
      to_enter_background_instruction_q  <= 1'b0;
    end else if (i_clk_en) begin
      rst_seen_q <= 1'b1;
      if (!rst_seen_q) begin
        to_enter_background_instruction_q <= ~ms_s2_q | i_force_reset;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= ST_RESET;
      stop_q  <= STOP_NONE;
      vec_q   <= VEC_RESET;
      pc_q    <= 16'h0000;
      pc_valid_q <= 1'b0;
    end else if (i_clk_en) begin
      pc_valid_q <= 1'b0;
      case (state_q)
        ST_RESET: begin
          if (rst_seen_q) begin
            if (to_enter_background_instruction_q) begin
              state_q <= ST_DEBUG;
            end else begin
              vec_q   <= VEC_RESET;
              state_q <= ST_VEC_HI;
            end
          end
        end
        ST_VEC_HI: begin
          if (i_byte_valid) begin
            pc_q[15:8] <= i_byte;
            state_q    <= ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (i_byte_valid) begin
            pc_q[7:0]  <= i_byte;
            pc_valid_q <= 1'b1;
            state_q    <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (bg_event) begin
            state_q <= ST_DEBUG;
          end else if (i_stop_instr && i_stop_sel != STOP_NONE) begin
            stop_q  <= i_stop_sel;
            state_q <= ST_STOP;
          end else if (i_wait_instr) begin
            state_q <= ST_WAIT;
          end else if (i_irq_req) begin
            vec_q   <= vec_addr;
            state_q <= ST_VEC_HI;
          end
        end
        ST_DEBUG: begin
          if (i_go_cmd) begin
            state_q <= ST_RUN;
          end
        end
        ST_WAIT: begin
          if (i_halt_cmd) begin
            state_q <= ST_DEBUG;
          end else if (i_irq_req) begin
            vec_q   <= vec_addr;
            state_q <= ST_VEC_HI;
          end
        end
        ST_STOP: begin
          // Stop1 and stop2 wake fetch the reset vector; stop3 may take the interrupt vector
          if (i_wake) begin
            stop_q <= STOP_NONE;
            if (stop_q == STOP_3) begin
              vec_q   <= i_irq_req ? vec_addr : VEC_RESET;
              state_q <= ST_VEC_HI;
            end else begin
              vec_q   <= VEC_RESET;
              state_q <= ST_VEC_HI;
            end
          end
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // ************************************************************
  // Stop2 pin hold and partial power-down flag
  // ************************************************************
  logic       hold_q;
  logic       ppd_flag_q;
  omvc_pins_t latch_q;
  logic       stop2_go;

  // Background entry outranks stop, so no hold is taken on that cycle
  assign stop2_go = (state_q == ST_RUN) && !bg_event && i_stop_instr && (i_stop_sel == STOP_2);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hold_q     <= 1'b0;
      ppd_flag_q <= 1'b0;
      latch_q    <= '0;
    end else if (i_clk_en) begin
      if (stop2_go) begin
        latch_q    <= i_port_regs;
        hold_q     <= 1'b1;
        ppd_flag_q <= 1'b1;
      end else if (i_ack_write && state_q != ST_STOP) begin
        hold_q     <= 1'b0;
        ppd_flag_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic in_stop, stop1;
  assign in_stop = (state_q == ST_STOP);
  assign stop1   = in_stop && (stop_q == STOP_1);

  always_comb begin
    if (stop1) begin
      o_pins = '{dat: PIN_RST_VAL, oe: PIN_RST_VAL, pue: PIN_RST_VAL};
    end else if (hold_q) begin
      o_pins = latch_q;
    end else begin
      o_pins = i_port_regs;
    end
  end

  // stop gates CPU and bus clocks
  assign o_cpu_clk_en     = ~in_stop & (state_q != ST_WAIT);
  assign o_bus_clk_en     = ~in_stop;
  assign o_regulator_full = ~in_stop;
  assign o_regs_powered   = ~(in_stop && stop_q != STOP_3);
  assign o_ram_retain     = ~stop1;
  assign o_pin_hold       = hold_q;
  assign o_ppd_flag       = ppd_flag_q;
  assign o_background     = (state_q == ST_DEBUG);
  assign o_run            = (state_q == ST_RUN);
  assign o_pc             = pc_q;
  assign o_pc_valid       = pc_valid_q;

  always_comb begin
    o_fetch.req  = (state_q == ST_VEC_HI) || (state_q == ST_VEC_LO);
    o_fetch.addr = (state_q == ST_VEC_LO) ? (vec_q | ADDR_HI_OFS) : vec_q;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_bg_ev;
    o_run && i_clk_en && bg_event;
  endsequence

  a_bg_entry: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_bg_ev |=> o_background) else $error("no background entry");
  a_hi_even: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state_q == ST_VEC_HI) |-> !o_fetch.addr[0]) else $error("high byte not even");
  a_lo_odd: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state_q == ST_VEC_LO) |-> o_fetch.addr[0]) else $error("low byte not odd");
  a_no_user: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_fetch.req |-> (o_fetch.addr > USER_HI)) else $error("fetch in user range");
  a_stop_clk: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    in_stop |-> !o_cpu_clk_en && !o_bus_clk_en) else $error("clock in stop");
  a_wait_clk: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state_q == ST_WAIT) |-> o_bus_clk_en && o_regulator_full && !o_cpu_clk_en)
    else $error("wait clocks wrong");
  a_stop1_pins: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    stop1 |-> (o_pins.oe == PIN_RST_VAL) && (o_pins.pue == PIN_RST_VAL))
    else $error("stop1 pin not default");
  a_hold_ack: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (hold_q && i_clk_en && i_ack_write && !in_stop && !stop2_go) |=> !o_pin_hold)
    else $error("ack did not release");
  a_run_vec: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(rst_seen_q) && !to_enter_background_instruction_q |=> o_fetch.req && (o_fetch.addr == VEC_RESET))
    else $error("reset vector not fetched");

endmodule

/* omvc_mem_model.sv */
/*
  Memory partner that answers the block's vector byte fetches.
  Assumes each fetch request is held until a byte has been handed back.
*/
`timescale 1ns/1ps
module omvc_mem_model #(
  parameter int LAT = 2
) (
  input  wire logic                  i_clock,
  input  wire omvc_pkg::omvc_fetch_t i_fetch,
  output logic                       o_byte_valid,
  output logic [7:0]                 o_byte
);
  import omvc_pkg::*;
  // ************************************************************
  // Byte answers
  // ************************************************************
  int cnt = 0;
  initial begin
    o_byte_valid = 1'b0;
    o_byte = 8'hA5;
  end
  always @(negedge i_clock) begin
    if (o_byte_valid) begin
      o_byte_valid <= 1'b0;
      // Released bus shows the inverse, never a stale copy
      o_byte <= ~o_byte;
    end else if (i_fetch.req && cnt >= LAT) begin
      o_byte_valid <= 1'b1;
      o_byte <= i_fetch.addr[7:0] ^ 8'h3C;
      cnt <= 0;
    end else begin
      o_byte <= ~o_byte;
      cnt <= i_fetch.req ? cnt + 1 : 0;
    end
  end
endmodule

/* omvc_top_bench.sv */
/*
  Self-checking bench for the mode and vector control block.
  Assumes the memory partner answers fetches and the bench plays software.
*/
`timescale 1ns/1ps
module omvc_top_bench;
  import omvc_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic         i_clock = 1'b0;
  logic         i_sys_rst = 1'b1;
  logic         i_mode_select_pin = 1'b1;
  logic         i_force_reset = 1'b0;
  logic         i_clk_en = 1'b1;
  logic [8:0]   ev = 9'h000;
  omvc_stop_t   i_stop_sel = STOP_NONE;
  logic         i_irq_req = 1'b0;
  omvc_src_t    i_irq_src = SRC_SWI;
  logic         i_byte_valid;
  logic [7:0]   i_byte;
  omvc_pins_t   i_port_regs = 24'h000000;
  omvc_pins_t   o_pins;
  omvc_fetch_t  o_fetch;
  logic [15:0]  o_pc;
  logic         o_background, o_run, o_cpu_clk_en, o_bus_clk_en, o_regulator_full;
  logic         o_regs_powered, o_ram_retain, o_pin_hold, o_ppd_flag, o_pc_valid;
  int           mismatches = 0;
  int           total_checks = 0;
  logic [15:0]  vtab [16] = '{16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8,
    16'hFFD6, 16'hFFD0};
  always #25 i_clock = ~i_clock;
  omvc_top omvc_top_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_mode_select_pin(i_mode_select_pin), .i_force_reset(i_force_reset),
    .i_halt_cmd(ev[0]), .i_bg_instr(ev[1]), .i_ctrl_break(ev[2]), .i_trace_break(ev[3]),
    .i_go_cmd(ev[4]), .i_wait_instr(ev[5]), .i_stop_instr(ev[6]), .i_stop_sel(i_stop_sel),
    .i_wake(ev[7]), .i_ack_write(ev[8]), .i_irq_req(i_irq_req), .i_irq_src(i_irq_src),
    .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_port_regs(i_port_regs),
    .o_pins(o_pins), .o_background(o_background), .o_run(o_run),
    .o_cpu_clk_en(o_cpu_clk_en), .o_bus_clk_en(o_bus_clk_en),
    .o_regulator_full(o_regulator_full), .o_regs_powered(o_regs_powered),
    .o_ram_retain(o_ram_retain), .o_pin_hold(o_pin_hold), .o_ppd_flag(o_ppd_flag),
    .o_fetch(o_fetch), .o_pc(o_pc), .o_pc_valid(o_pc_valid));
  omvc_mem_model #(.LAT(2)) omvc_mem_model_inst (.i_clock(i_clock), .i_fetch(o_fetch),
    .o_byte_valid(i_byte_valid), .o_byte(i_byte));
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic report(logic [23:0] got, logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(logic got, logic exp);
    report({23'h0, got}, {23'h0, exp});
  endtask
  task automatic check_word(logic [15:0] got, logic [15:0] exp);
    report({8'h00, got}, {8'h00, exp});
  endtask
  task automatic check_pins(omvc_pins_t got, omvc_pins_t exp);
    report(got, exp);
  endtask
  function automatic logic probe(int k);
    return (k == 0) ? o_run : (k == 1) ? o_background : (k == 2) ? o_pc_valid : o_fetch.req;
  endfunction
  // Bounded wait, the result counts as a comparison
  task automatic wait_for(int k);
    int n;
    n = 0;
    while (probe(k) !== 1'b1 && n < 60) begin
      @(negedge i_clock);
      n++;
    end
    check_bit(probe(k), 1'b1);
  endtask
  task automatic pulse(int k);
    @(negedge i_clock);
    ev[k] = 1'b1;
    @(negedge i_clock);
    ev = 9'h000;
  endtask
  task automatic do_reset(logic pin, logic frc);
    @(negedge i_clock);
    i_sys_rst = 1'b1;
    i_mode_select_pin = pin;
    i_force_reset = frc;
    repeat (4) @(negedge i_clock);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    i_force_reset = 1'b0;
  endtask
  task automatic fetch_check(logic [15:0] a);
    wait_for(3);
    i_irq_req = 1'b0;
    check_word(o_fetch.addr, a);
    wait_for(2);
    check_word(o_pc, {a[7:0] ^ 8'h3C, (a[7:0] | 8'h01) ^ 8'h3C});
    wait_for(0);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot;
    do_reset(1'b1, 1'b0);
    fetch_check(16'hFFFE);
    check_bit(o_background, 1'b0);
    do_reset(1'b0, 1'b0);
    wait_for(1);
    check_bit(o_fetch.req, 1'b0);
    do_reset(1'b1, 1'b1);
    wait_for(1);
    check_bit(o_run, 1'b0);
    $display("test boot done");
  endtask
  task automatic t_events;
    do_reset(1'b1, 1'b0);
    fetch_check(16'hFFFE);
    // Frozen block must ignore an event
    i_clk_en = 1'b0;
    pulse(0);
    check_bit(o_run, 1'b1);
    i_clk_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      wait_for(1);
      check_bit(o_run, 1'b0);
      pulse(4);
      wait_for(0);
    end
    $display("test events done");
  endtask
  task automatic t_vectors;
    for (int k = 0; k < 16; k++) begin
      i_irq_src = omvc_src_t'(k);
      i_irq_req = 1'b1;
      fetch_check(vtab[k]);
    end
    pulse(5);
    check_bit(o_cpu_clk_en, 1'b0);
    check_bit(o_bus_clk_en, 1'b1);
    check_bit(o_regulator_full, 1'b1);
    $display("test vectors done");
  endtask
  task automatic t_stops;
    do_reset(1'b1, 1'b0);
    fetch_check(16'hFFFE);
    i_port_regs = 24'hFFFFFF;
    i_stop_sel = STOP_1;
    pulse(6);
    check_bit(o_bus_clk_en | o_cpu_clk_en, 1'b0);
    check_bit(o_regs_powered, 1'b0);
    check_pins(o_pins, 24'h000000);
    pulse(7);
    fetch_check(16'hFFFE);
    i_port_regs = 24'h5A3C81;
    i_stop_sel = STOP_2;
    pulse(6);
    i_port_regs = 24'h0F0F0F;
    check_pins(o_pins, 24'h5A3C81);
    check_bit(o_ram_retain, 1'b1);
    pulse(8);
    check_bit(o_pin_hold, 1'b1);
    pulse(7);
    fetch_check(16'hFFFE);
    check_bit(o_ppd_flag, 1'b1);
    check_pins(o_pins, 24'h5A3C81);
    pulse(8);
    check_bit(o_pin_hold | o_ppd_flag, 1'b0);
    check_pins(o_pins, 24'h0F0F0F);
    i_port_regs = 24'hC3A5F0;
    i_stop_sel = STOP_3;
    pulse(6);
    check_bit(o_regs_powered & o_ram_retain, 1'b1);
    check_bit(o_bus_clk_en, 1'b0);
    check_pins(o_pins, 24'hC3A5F0);
    i_irq_src = SRC_IRQ;
    i_irq_req = 1'b1;
    pulse(7);
    fetch_check(16'hFFFA);
    $display("test stops done");
  endtask
  // ************************************************************
  // Run control
  // ************************************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // 20000 clock cycles, tens of times the expected length of all scenarios
  initial begin
    #(20000 * 50);
    mismatches++;
    conclude();
  end
  initial begin
    t_boot();
    t_events();
    t_vectors();
    t_stops();
    conclude();
  end
endmodule
